/* File: pde_defs.svh */
/*
 * Constants for the port pin direction enable block: register indices,
 * implemented-bit masks, reset values and the AXI4-Lite answer codes.
 * Assumes it is included by the package and the design files by bare name.
 */
// How it works
// R1 - A set port F drive enable bit for pins 7 to 0 turns that pin's driver on, a clear bit keeps it off.
// R2 - Port G drive enables live at index 30B6h, bits 3 to 0 each switch one pin driver on when set.
// R3 - Port G bits 7 to 4 are read-only, always read zero and ignore writes.
// R4 - Port H drive enables live at index 30B7h and only bits 7, 6, 2, 1 and 0 exist.
// R5 - Port H bits 5 to 3 are read-only and always read zero.
// R6 - Port A sense enables live at index 30B8h, bits 7, 6, 5, 3, 2, 1, 0 connect the input path when set.
// R7 - Port A bit 4 is read-only and always reads zero whatever is written.
// R8 - Every implemented drive enable bit of ports F, G and H reads back the value last written.
// R9 - Every implemented port A sense enable bit reads back the value last written.
// R10 - Reset clears every drive and sense enable bit, so all drivers and input paths start off.
`ifndef PDE_DEFS_SVH
`define PDE_DEFS_SVH

// Register indices; byte address is four times the index
`define PDE_IDX_PORT_F 16'h30B5
`define PDE_IDX_PORT_G 16'h30B6
`define PDE_IDX_PORT_H 16'h30B7
`define PDE_IDX_PORT_A 16'h30B8
`define PDE_IDX_STATUS 16'h30C0

// Implemented bits of each register
`define PDE_MASK_PORT_F 8'hFF
`define PDE_MASK_PORT_G 8'h0F
`define PDE_MASK_PORT_H 8'hC7
`define PDE_MASK_PORT_A 8'hEF

// Reset value of every enable register
`define PDE_RESET_ENABLES 8'h00

// Positions in the decoded select vector
`define PDE_SEL_F 0
`define PDE_SEL_G 1
`define PDE_SEL_H 2
`define PDE_SEL_A 3
`define PDE_SEL_S 4
`define PDE_SEL_W 5

// AXI response codes
`define PDE_RESP_OKAY 2'h0
`define PDE_RESP_SLVERR 2'h2

`endif

/* File: pde_pkg.sv */
/*
 * Types shared by the pin direction enable block.
 * Assumes pde_defs.svh is on the include path.
 */
`default_nettype none
`include "pde_defs.svh"

package pde_pkg;

	// One register write: strobe with its byte
	typedef struct packed {
		logic en;
		logic [7:0] data;
	} pde_wr_s;

	// Decoded register selection, one bit per register
	typedef logic [`PDE_SEL_W-1:0] pde_sel_t;

endpackage
`default_nettype wire

/* File: pde_enable_reg.sv */
/*
 * One 8-bit enable register whose unimplemented bits are hard zero.
 * Assumes writes arrive as a one-cycle strobe on the block clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pde_defs.svh"

module pde_enable_reg
	import pde_pkg::*;
#(
	parameter logic [7:0] MASK = 8'hFF
) (
	input wire logic mclk_i, // Block clock
	input wire logic rst_i, // Synchronous reset, high
	input wire pde_wr_s wr_i, // Write strobe and byte
	output logic [7:0] q_o // Stored enables
);

	logic [7:0] store;

	// Store only implemented bits; reserved bits stay zero
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			store <= `PDE_RESET_ENABLES; // R10
		end else if (wr_i.en) begin
			store <= wr_i.data & MASK; // R3 R8 R9
		end
	end

	assign q_o = store & MASK;

endmodule
`default_nettype wire

/* File: pde_top.sv */
/*
 * Port pin direction enables: drive enables for ports F, G and H and
 * sense enables for port A, held in registers reached over AXI4-Lite.
 * Port data arrives from data-register logic on the same clock; the
 * port A pins arrive from outside and are synchronised here.
 * Assumes one clock, mclk_i, and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pde_defs.svh"

module pde_top
	import pde_pkg::*;
(
	input wire logic mclk_i, // Block clock, 125 MHz
	input wire logic rst_i, // Synchronous reset, high
	// AXI4-Lite write address
	input wire logic [31:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte enables
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	// AXI4-Lite read address
	input wire logic [31:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	// Port F, G, H pin drivers
	input wire logic [7:0] port_f_data_i, // Port F output data
	input wire logic [3:0] port_g_data_i, // Port G output data
	input wire logic [7:0] port_h_data_i, // Port H output data
	output logic [7:0] port_f_pin_o, // Port F pin output level
	output logic [7:0] port_f_pin_oe_n_o, // Port F driver on, low
	output logic [3:0] port_g_pin_o, // Port G pin output level
	output logic [3:0] port_g_pin_oe_n_o, // Port G driver on, low
	output logic [7:0] port_h_pin_o, // Port H pin output level
	output logic [7:0] port_h_pin_oe_n_o, // Port H driver on, low
	// Port A input path
	input wire logic [7:0] port_a_pin_i, // Port A pin levels
	output logic [7:0] port_a_data_o // Port A sensed levels
);

	// Enable register contents
	logic [7:0] port_f_drive_enable;
	logic [7:0] port_g_drive_enable;
	logic [7:0] port_h_drive_enable;
	logic [7:0] port_a_sense_enable;

	// Write path holding state
	logic aw_held;
	logic w_held;
	logic [31:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane0;
	logic wr_go;
	pde_sel_t wr_sel;
	pde_sel_t rd_sel;
	logic [7:0] rd_byte;

	// Per-register write strobes
	pde_wr_s wr_f;
	pde_wr_s wr_g;
	pde_wr_s wr_h;
	pde_wr_s wr_a;

	// Port A synchroniser stages and settled level
	logic [7:0] pa_s1;
	logic [7:0] pa_s2;
	logic [7:0] pa_s3;
	logic [7:0] pa_level;

	// Map a byte address onto the register it selects
	function automatic pde_sel_t pde_decode(input logic [31:0] addr);
		pde_sel_t sel;
		sel = '0;
		if (addr == {14'h0000, `PDE_IDX_PORT_F, 2'b00}) begin
			sel[`PDE_SEL_F] = 1'b1;
		end
		if (addr == {14'h0000, `PDE_IDX_PORT_G, 2'b00}) begin
			sel[`PDE_SEL_G] = 1'b1; // R2
		end
		if (addr == {14'h0000, `PDE_IDX_PORT_H, 2'b00}) begin
			sel[`PDE_SEL_H] = 1'b1; // R4
		end
		if (addr == {14'h0000, `PDE_IDX_PORT_A, 2'b00}) begin
			sel[`PDE_SEL_A] = 1'b1; // R6
		end
		if (addr == {14'h0000, `PDE_IDX_STATUS, 2'b00}) begin
			sel[`PDE_SEL_S] = 1'b1;
		end
		return sel;
	endfunction

	// Address and data channels are refused while a response waits
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	// Write commits once both halves are held
	assign wr_go = aw_held & w_held & ~s_axi_bvalid;
	assign wr_sel = pde_decode(aw_addr);

	// Hold the write address until the commit
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			aw_held <= 1'b0;
			aw_addr <= 32'h0000_0000;
		end else if (wr_go) begin
			aw_held <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
	end

	// Hold the low data byte and its lane strobe until the commit
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			w_held <= 1'b0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
		end else if (wr_go) begin
			w_held <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_byte <= s_axi_wdata[7:0];
			w_lane0 <= s_axi_wstrb[0];
		end
	end

	// Write response, error for an unmapped address
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PDE_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (|wr_sel) ? `PDE_RESP_OKAY : `PDE_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Strobes into the enable registers; byte lane 0 carries the bits
	always_comb begin
		wr_f.en = wr_go & w_lane0 & wr_sel[`PDE_SEL_F]; // R8
		wr_g.en = wr_go & w_lane0 & wr_sel[`PDE_SEL_G]; // R8
		wr_h.en = wr_go & w_lane0 & wr_sel[`PDE_SEL_H]; // R8
		wr_a.en = wr_go & w_lane0 & wr_sel[`PDE_SEL_A]; // R9
		wr_f.data = w_byte;
		wr_g.data = w_byte;
		wr_h.data = w_byte;
		wr_a.data = w_byte;
	end

	// Port F enables, all eight bits writable
	pde_enable_reg #(
		.MASK(`PDE_MASK_PORT_F)
	) u_port_f (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.wr_i(wr_f),
		.q_o(port_f_drive_enable)
	);

	// Port G enables, upper nibble hard zero
	pde_enable_reg #(
		.MASK(`PDE_MASK_PORT_G) // R3
	) u_port_g (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.wr_i(wr_g),
		.q_o(port_g_drive_enable)
	);

	// Port H enables, bits 5 to 3 hard zero
	pde_enable_reg #(
		.MASK(`PDE_MASK_PORT_H) // R5
	) u_port_h (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.wr_i(wr_h),
		.q_o(port_h_drive_enable)
	);

	// Port A sense enables, bit 4 hard zero
	pde_enable_reg #(
		.MASK(`PDE_MASK_PORT_A) // R7
	) u_port_a (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.wr_i(wr_a),
		.q_o(port_a_sense_enable)
	);

	// Read data select for the requested register
	always_comb begin
		rd_sel = pde_decode(s_axi_araddr);
		rd_byte = 8'h00;
		case (1'b1)
			rd_sel[`PDE_SEL_F]: rd_byte = port_f_drive_enable; // R8
			rd_sel[`PDE_SEL_G]: rd_byte = port_g_drive_enable; // R3 R8
			rd_sel[`PDE_SEL_H]: rd_byte = port_h_drive_enable; // R5 R8
			rd_sel[`PDE_SEL_A]: rd_byte = port_a_sense_enable; // R7 R9
			rd_sel[`PDE_SEL_S]: rd_byte = port_a_data_o;
			default: rd_byte = 8'h00;
		endcase
	end

	// Read answer one edge after the address is taken
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `PDE_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_byte};
			s_axi_rresp <= (|rd_sel) ? `PDE_RESP_OKAY : `PDE_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Pin output levels registered from the data logic
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			port_f_pin_o <= 8'h00;
			port_g_pin_o <= 4'h0;
			port_h_pin_o <= 8'h00;
		end else begin
			port_f_pin_o <= port_f_data_i;
			port_g_pin_o <= port_g_data_i;
			port_h_pin_o <= port_h_data_i;
		end
	end

	// Driver enables straight from the enable registers
	assign port_f_pin_oe_n_o = ~port_f_drive_enable; // R1
	assign port_g_pin_oe_n_o = ~port_g_drive_enable[3:0]; // R2
	assign port_h_pin_oe_n_o = ~port_h_drive_enable; // R4

	// Port A pins pass three flops; a change counts when stages 2 and 3 agree
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pa_sync
			always_ff @(posedge mclk_i) begin
				if (rst_i) begin
					pa_s1[gi] <= 1'b0;
					pa_s2[gi] <= 1'b0;
					pa_s3[gi] <= 1'b0;
					pa_level[gi] <= 1'b0;
				end else begin
					pa_s1[gi] <= port_a_pin_i[gi];
					pa_s2[gi] <= pa_s1[gi];
					pa_s3[gi] <= pa_s2[gi];
					if (pa_s2[gi] == pa_s3[gi]) begin
						pa_level[gi] <= pa_s3[gi];
					end
				end
			end
		end
	endgenerate

	// Disconnected input paths read as zero
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			port_a_data_o <= 8'h00;
		end else begin
			port_a_data_o <= pa_level & port_a_sense_enable; // R6
		end
	end

endmodule
`default_nettype wire

/* File: pde_top_chk.sv */
/*
 * Checker for the pin direction enable block, bound to pde_top.
 * Assumes one clock and the synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none

module pde_top_chk (
	input wire logic mclk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic [31:0] s_axi_awaddr, // Addr
	input wire logic s_axi_awvalid, // Valid
	input wire logic s_axi_awready, // Ready
	input wire logic [31:0] s_axi_wdata, // Data
	input wire logic [3:0] s_axi_wstrb, // Strobes
	input wire logic s_axi_wvalid, // Valid
	input wire logic s_axi_wready, // Ready
	input wire logic s_axi_bvalid, // Answer
	input wire logic [31:0] s_axi_araddr, // Addr
	input wire logic s_axi_arvalid, // Valid
	input wire logic s_axi_arready, // Ready
	input wire logic [31:0] s_axi_rdata, // Data
	input wire logic s_axi_rvalid, // Answer
	input wire logic [7:0] port_f_pin_oe_n_o, // F off
	input wire logic [3:0] port_g_pin_oe_n_o, // G off
	input wire logic [7:0] port_h_pin_oe_n_o, // H off
	input wire logic [7:0] port_a_data_o // A sensed
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	logic [31:0] wa;
	logic [31:0] ra;
	logic [7:0] wd;
	logic ws;

	// Latch each accepted address and data
	always_ff @(posedge mclk_i) begin
		if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
		if (s_axi_wvalid && s_axi_wready) ws <= s_axi_wstrb[0];
		if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
	end

	chk_f_commit: assert property ($rose(s_axi_bvalid) && ws && wa == 32'h0000_C2D4
		|-> port_f_pin_oe_n_o == ~wd) else $error("port F drivers differ from write");
	chk_g_commit: assert property ($rose(s_axi_bvalid) && ws && wa == 32'h0000_C2D8
		|-> port_g_pin_oe_n_o == ~wd[3:0]) else $error("port G drivers differ from write");
	chk_h_commit: assert property ($rose(s_axi_bvalid) && ws && wa == 32'h0000_C2DC
		|-> port_h_pin_oe_n_o == ~(wd & 8'hC7)) else $error("port H drivers differ");
	chk_h_resv_off: assert property (port_h_pin_oe_n_o[5:3] == 3'h7)
		else $error("reserved port H driver on");
	chk_oe_quiet: assert property (!$rose(s_axi_bvalid)
		|-> $stable(port_g_pin_oe_n_o) && $stable(port_h_pin_oe_n_o))
		else $error("drivers changed without a write");
	chk_a_resv: assert property (port_a_data_o[4] == 1'b0)
		else $error("reserved port A input sensed");
	chk_g_rd_resv: assert property (s_axi_rvalid && ra == 32'h0000_C2D8
		|-> s_axi_rdata[7:4] == 4'h0) else $error("port G upper bits read nonzero");
	chk_rd_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_reset_off: assert property ($fell(rst_i)
		|-> &port_f_pin_oe_n_o && &port_g_pin_oe_n_o && &port_h_pin_oe_n_o)
		else $error("driver on after reset");
endmodule

bind pde_top pde_top_chk u_pde_top_chk (.*);

`default_nettype wire

/* File: pde_top_bench.sv */
/*
 * Self-checking bench for pde_top over AXI4-Lite.
 * Assumes the checker file is compiled alongside.
 */
`timescale 1ns/10ps
`default_nettype none

module pde_top_bench;
	logic mclk_i = 0;
	logic rst_i = 1;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 0, port_g_data_i = 0, port_g_pin_o, port_g_pin_oe_n_o;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] port_f_data_i = 0, port_h_data_i = 0, port_a_pin_i = 0;
	logic [7:0] port_f_pin_o, port_f_pin_oe_n_o, port_h_pin_o, port_h_pin_oe_n_o;
	logic [7:0] port_a_data_o;
	int n_mismatch = 0, check_count = 0;
	localparam logic [31:0] ADR [4] = '{32'h0000_C2D4, 32'h0000_C2D8, 32'h0000_C2DC,
		32'h0000_C2E0};
	localparam logic [7:0] MSK [4] = '{8'hFF, 8'h0F, 8'hC7, 8'hEF};
	logic [7:0] m [4] = '{8'h00, 8'h00, 8'h00, 8'h00};

	pde_top u_pde_top (.*);

	// Clock, 8 ns period
	initial begin
		forever #4 mclk_i = ~mclk_i;
	end

	// Watchdog
	initial begin
		repeat (4000) @(posedge mclk_i);
		n_mismatch++;
		finish_test();
	end

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One write; an edge passes first so calls in a row never drive twice in one step
	// Readies sampled mid-cycle, equal to their edge values; only the watchdog ends a wait
	task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic s0,
		output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge mclk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0000_00, d};
		s_axi_wstrb <= {3'h0, s0};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tb = 0;
		while (!tb) begin
			@(negedge mclk_i);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge mclk_i);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask

	// One read; an edge passes first, and only the watchdog ends a wait
	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		@(posedge mclk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tr = 0;
		while (!tr) begin
			@(negedge mclk_i);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge mclk_i);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask

	// Write, then read back and compare both answers
	task automatic wr_rd(input int i, input logic [7:0] d, input logic s0, input logic [1:0] e);
		logic [31:0] q;
		logic [1:0] r;
		wr(ADR[i], d, s0, r);
		chk(r, e);
		rd(ADR[i], q, r);
		chk(r, e);
		chk(q, m[i]);
	endtask

	// Driver enables against the expected registers; XOR keeps each inversion at its port's width, 8 bits for F and H, 4 for G
	task automatic chk_oe();
		chk(port_f_pin_oe_n_o ^ 8'hFF, m[0]);
		chk(port_g_pin_oe_n_o ^ 4'hF, m[1][3:0]);
		chk(port_h_pin_oe_n_o ^ 8'hFF, m[2]);
	endtask

	task automatic t_reset();
		logic [31:0] q;
		logic [1:0] r;
		m = '{8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 4; i++) begin
			rd(ADR[i], q, r);
			chk(q, 32'h0000_0000);
		end
		chk_oe();
	endtask

	task automatic t_walk();
		logic [7:0] p [4] = '{8'hFF, 8'h5A, 8'hA5, 8'h00};
		for (int i = 0; i < 4; i++) begin
			for (int k = 0; k < 4; k++) begin
				m[i] = p[k] & MSK[i];
				wr_rd(i, p[k], 1'b1, 2'h0);
				chk_oe();
			end
		end
	endtask

	task automatic t_refuse();
		logic [31:0] q;
		logic [1:0] r;
		m[1] = 8'h06;
		wr_rd(1, 8'h06, 1'b1, 2'h0);
		wr_rd(1, 8'hF9, 1'b0, 2'h0);
		wr(32'h0001_82E4, 8'hFF, 1'b1, r);
		chk(r, 2'h2);
		rd(32'h0001_82E4, q, r);
		chk(r, 2'h2);
		chk_oe();
	endtask

	task automatic t_port_a();
		logic [31:0] q;
		logic [1:0] r;
		port_f_data_i <= 8'h3C;
		port_g_data_i <= 4'h9;
		port_h_data_i <= 8'hC3;
		port_a_pin_i <= 8'hFF;
		m[3] = 8'hEF;
		wr_rd(3, 8'hFF, 1'b1, 2'h0);
		repeat (6) @(posedge mclk_i);
		chk(port_a_data_o, 8'hEF);
		m[3] = 8'h21;
		wr_rd(3, 8'h21, 1'b1, 2'h0);
		repeat (6) @(posedge mclk_i);
		chk(port_a_data_o, 8'h21);
		port_a_pin_i <= 8'h01;
		repeat (6) @(posedge mclk_i);
		chk(port_a_data_o, 8'h01);
		chk(port_f_pin_o, 8'h3C);
		chk(port_g_pin_o, 4'h9);
		chk(port_h_pin_o, 8'hC3);
		rd(32'h0000_C300, q, r);
		chk(q, 32'h0000_0001);
		chk(r, 2'h0);
	endtask

	// Mid-run reset with enables set
	task automatic t_rerst();
		m[0] = 8'h81;
		wr_rd(0, 8'h81, 1'b1, 2'h0);
		rst_i <= 1'b1;
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		t_reset();
	endtask

	initial begin
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		t_reset();
		t_walk();
		t_refuse();
		t_port_a();
		t_rerst();
		finish_test();
	end
endmodule

`default_nettype wire
